// ### hdl/cem_pkg.sv
// Purpose: Shared constants, command codes and carriers for the chassis event monitor.
// Assumes: One 50 MHz clock; commands arrive already parsed into the command struct.
// Notes: Bit positions follow the status tables of the condition registers.
package cem_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Event sources and counting
    localparam int NUM_SRC = 8;
    localparam int SRC_W = 3;
    localparam int LIMIT_W = 8;
    localparam int CNT_W = 9;
    localparam logic [CNT_W-1:0] CNT_SAT = 9'h100;
    localparam logic [SRC_W-1:0] SRC_BUS_FAULT = 3'h0;
    localparam logic [LIMIT_W-1:0] LIMIT_RST = 8'h00;
    localparam logic [SRC_W-1:0] SRC_RST = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Status registers
    localparam int REG_W = 16;
    localparam int NUM_ATTR = 6;
    localparam logic [REG_W-1:0] REG_RST = 16'h0000;
    localparam int VOLT_BITS = 7;
    localparam int SLOT_BITS = 13;
    localparam int AMBIENT_BIT = 13;
    localparam int FAN_ANY_BIT = 0;
    localparam int FAN_ONE_BIT = 1;
    localparam int BUS_FAULT_BIT = 0;
    localparam int SYSFAIL_BIT = 1;
    localparam int ACFAIL_BIT = 2;
    localparam int ACK_LEVEL_BIT = 3;
    localparam int RSP_LATENCY = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Commands and attributes
    typedef enum logic [2:0] {
        CEM_OP_LIMIT_SET,
        CEM_OP_LIMIT_QUERY,
        CEM_OP_COUNT_QUERY,
        CEM_OP_COUNT_ZERO,
        CEM_OP_COND_QUERY,
        CEM_OP_EVENT_QUERY,
        CEM_OP_ENABLE_SET,
        CEM_OP_ENABLE_QUERY
    } cem_op_e;

    typedef enum logic [2:0] {
        CEM_ATTR_VOLT,
        CEM_ATTR_CURR,
        CEM_ATTR_TEMP,
        CEM_ATTR_FAN,
        CEM_ATTR_TIME,
        CEM_ATTR_BUS
    } cem_attr_e;

    typedef logic [REG_W-1:0] cem_reg_t;

    typedef struct packed {
        cem_op_e op;
        logic [SRC_W-1:0] source;
        cem_attr_e attr;
        logic [REG_W-1:0] data;
    } cem_cmd_s;

    typedef struct packed {
        logic [6:0] volt;
        logic [6:0] curr;
        logic [12:0] slot;
        logic ambient;
        logic [2:0] fan;
        logic [2:0] elapsed;
    } cem_fault_s;

endpackage

// ### hdl/cem_limit_mem.sv
// Purpose: Small store of per-source limits with a registered read port.
// Assumes: One write and one read per cycle, synchronous active-low reset.
// Notes: Read data appear one edge after the address; all words reset to zero.
`timescale 1ns/1ps
`default_nettype none
module cem_limit_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 8,
    parameter int AW = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // Read port
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    import cem_pkg::*;

    logic [WIDTH-1:0] mem [DEPTH];

    // Refuse a depth the address cannot reach
    if (DEPTH > (1 << AW) || DEPTH < 1 || WIDTH < 1)
    begin : g_bad
        $error("cem_limit_mem: depth does not fit the address width");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage and registered read
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem[i] <= '0;
            end
            rd_data <= '0;
        end
        else
        begin
            if (wr_en)
            begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end

endmodule
`default_nettype wire

// ### hdl/cem_monitor.sv
// Purpose: Backplane fault/acknowledge counter and first status tier of the chassis monitor.
// Assumes: Backplane lines are asynchronous pins; fault inputs come from logic on clk.
// Notes: Every command is answered exactly two edges after it is taken.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Only one event source watched at once
// - Writing a limit selects that source alone
// - Limits are 0 to 255 only
// - Limit zero stops all event monitoring
// - Limit query returns stored source limit
// - Count query nonzero only for watched source
// - Counter counts events, saturates at 256
// - Saturated count cleared by zero or reselect
// - Clear acts only on the watched source
// - Three-tier status hierarchy, per-attribute enables
// - Condition, event, enable per six attributes
// - Condition bits show live state, unlatched
// - Voltage bits +5 -5.2 -2 +24 -24 +12 -12
// - Voltage condition reads 0..127, upper zero
// - Current bits in same supply order
// - Slot rise bits 0-12, ambient bit 13
// - Fan bit 0 any, bits 1-3 each
// - Time bits: present, cumulative, filter service
// - Bus bits: fault 0, ack levels 3-9
// - Event bits set on rise, clear on read
// - Event AND enable ORed to summary bit
module cem_monitor #(
    parameter int SOURCES = cem_pkg::NUM_SRC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Backplane pins, active low except the ack_level code
    input wire logic bus_error_n,
    input wire logic ack_strobe_n,
    input wire logic [cem_pkg::SRC_W-1:0] ack_level,
    input wire logic sysfail_n,
    input wire logic acfail_n,
    // Live fault levels from the sensor logic
    input wire cem_pkg::cem_fault_s faults,
    // Host command port
    input wire logic cmd_valid,
    input wire cem_pkg::cem_cmd_s cmd,
    // Host answer port
    output logic rsp_valid,
    output logic rsp_error,
    output logic [cem_pkg::REG_W-1:0] rsp_data,
    // Summary bits to the next status tier
    output logic [cem_pkg::NUM_ATTR-1:0] summary
);
    import cem_pkg::*;

    // Refuse a source count the counter logic cannot serve
    if (SOURCES != NUM_SRC)
    begin : g_bad
        $error("cem_monitor: exactly eight event sources are supported");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // One-hot position of a source among the counted sources
    function automatic logic [NUM_SRC-1:0] src_onehot(input logic [SRC_W-1:0] s);
        return 8'h01 << s;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [6:0] pin_meta;
    logic [6:0] pin_sync;
    logic [6:0] pin_prev;
    logic [SRC_W-1:0] sel_src;
    logic monitor_on;
    logic [LIMIT_W-1:0] active_limit;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    cem_reg_t cond [NUM_ATTR];
    cem_reg_t ev [NUM_ATTR];
    cem_reg_t en [NUM_ATTR];
    cem_reg_t next_cond [NUM_ATTR];
    logic [NUM_ATTR-1:0] ev_clr;
    logic [NUM_ATTR-1:0] next_summary;
    logic q_valid;
    logic q_error;
    logic q_is_limit;
    cem_reg_t q_data;
    logic [LIMIT_W-1:0] mem_rd_data;

    ////////////////////////////////////////////////////////////////////////////
    // Backplane synchroniser: two flops, then a third for edge detection
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pin_meta <= 7'h7f;
            pin_sync <= 7'h7f;
            pin_prev <= 7'h7f;
        end
        else
        begin
            pin_meta <= {acfail_n, sysfail_n, ack_level, ack_strobe_n, bus_error_n};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Falling edges mark one distinct fault assertion or one ack cycle
    wire fault_fall = !pin_sync[0] && pin_prev[0];
    wire ack_fall = !pin_sync[1] && pin_prev[1];
    wire [SRC_W-1:0] ack_lvl = pin_sync[4:2];
    wire sysfail_on = !pin_sync[5];
    wire acfail_on = !pin_sync[6];

    ////////////////////////////////////////////////////////////////////////////
    // Command decode
    wire [2:0] attr_idx = cmd.attr;
    wire attr_ok = attr_idx < 3'(NUM_ATTR);
    wire lim_in_range = cmd.data[REG_W-1:LIMIT_W] == '0;
    wire lim_wr = cmd_valid && cmd.op == CEM_OP_LIMIT_SET && lim_in_range;
    wire new_src = lim_wr && cmd.source != sel_src;
    wire zero_hit = cmd_valid && cmd.op == CEM_OP_COUNT_ZERO && cmd.source == sel_src;
    wire en_wr = cmd_valid && cmd.op == CEM_OP_ENABLE_SET && attr_ok;
    wire attr_op = cmd.op == CEM_OP_COND_QUERY || cmd.op == CEM_OP_EVENT_QUERY
        || cmd.op == CEM_OP_ENABLE_SET || cmd.op == CEM_OP_ENABLE_QUERY;
    wire cmd_bad = (cmd.op == CEM_OP_LIMIT_SET && !lim_in_range) || (attr_op && !attr_ok);

    ////////////////////////////////////////////////////////////////////////////
    // Source selection and event counting
    wire src_is_fault = sel_src == SRC_BUS_FAULT;
    wire ack_match = ack_fall && ack_lvl == sel_src;
    wire ev_hit = monitor_on && (src_is_fault ? fault_fall : ack_match);
    wire cnt_clr = new_src || zero_hit;
    wire cnt_full = count == CNT_SAT;
    wire over_limit = monitor_on && count > {1'b0, active_limit};
    wire [NUM_SRC-1:0] src_over = over_limit ? src_onehot(sel_src) : '0;

    // Clear takes priority over a coincident event; count stops at its ceiling
    assign next_count = cnt_clr ? '0 : (ev_hit && !cnt_full) ? count + 9'h001 : count;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sel_src <= SRC_RST;
            monitor_on <= 1'b0;
            active_limit <= LIMIT_RST;
            count <= '0;
        end
        else
        begin
            if (lim_wr)
            begin
                sel_src <= cmd.source;
                monitor_on <= cmd.data[LIMIT_W-1:0] != '0;
                active_limit <= cmd.data[LIMIT_W-1:0];
            end
            count <= next_count;
        end
    end

    // Per-source limit store for readback
    cem_limit_mem #(
        .DEPTH(NUM_SRC),
        .WIDTH(LIMIT_W),
        .AW(SRC_W)
    ) u_limits (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(lim_wr),
        .wr_addr(cmd.source),
        .wr_data(cmd.data[LIMIT_W-1:0]),
        .rd_addr(cmd.source),
        .rd_data(mem_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Live condition values, unused bits held at zero
    assign next_cond[CEM_ATTR_VOLT] = {9'h000, faults.volt};
    assign next_cond[CEM_ATTR_CURR] = {9'h000, faults.curr};
    assign next_cond[CEM_ATTR_TEMP] = {2'h0, faults.ambient, faults.slot};
    assign next_cond[CEM_ATTR_FAN] = {12'h000, faults.fan, |faults.fan};
    assign next_cond[CEM_ATTR_TIME] = {13'h0000, faults.elapsed};
    assign next_cond[CEM_ATTR_BUS] = {6'h00, src_over[NUM_SRC-1:1], acfail_on,
        sysfail_on, src_over[0]};

    // Event read strobes and summary terms per attribute
    always_comb
    begin
        for (int a = 0; a < NUM_ATTR; a++)
        begin
            ev_clr[a] = cmd_valid && cmd.op == CEM_OP_EVENT_QUERY && attr_idx == 3'(a);
            next_summary[a] = |(ev[a] & en[a]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Condition, event and enable registers per attribute
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (int a = 0; a < NUM_ATTR; a++)
            begin
                cond[a] <= REG_RST;
                ev[a] <= REG_RST;
                en[a] <= REG_RST;
            end
            summary <= '0;
        end
        else
        begin
            for (int a = 0; a < NUM_ATTR; a++)
            begin
                cond[a] <= next_cond[a];
                ev[a] <= (ev_clr[a] ? REG_RST : ev[a]) | (next_cond[a] & ~cond[a]);
                if (en_wr && attr_idx == 3'(a))
                begin
                    en[a] <= cmd.data;
                end
            end
            summary <= next_summary;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Answer pipeline: stage one picks the value, stage two merges limit readback
    wire [CNT_W-1:0] cnt_view = (cmd.source == sel_src) ? count : '0;
    wire [2:0] rd_idx = attr_ok ? attr_idx : 3'h0;
    wire cem_reg_t rd_value = (!attr_ok && attr_op) ? REG_RST
        : (cmd.op == CEM_OP_COUNT_QUERY) ? {7'h00, cnt_view}
        : (cmd.op == CEM_OP_COND_QUERY) ? cond[rd_idx]
        : (cmd.op == CEM_OP_EVENT_QUERY) ? ev[rd_idx]
        : (cmd.op == CEM_OP_ENABLE_QUERY) ? en[rd_idx]
        : REG_RST;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            q_valid <= 1'b0;
            q_error <= 1'b0;
            q_is_limit <= 1'b0;
            q_data <= REG_RST;
            rsp_valid <= 1'b0;
            rsp_error <= 1'b0;
            rsp_data <= REG_RST;
        end
        else
        begin
            q_valid <= cmd_valid;
            q_error <= cmd_valid && cmd_bad;
            q_is_limit <= cmd_valid && cmd.op == CEM_OP_LIMIT_QUERY;
            q_data <= cmd_valid ? rd_value : REG_RST;
            rsp_valid <= q_valid;
            rsp_error <= q_error;
            rsp_data <= q_is_limit ? {8'h00, mem_rd_data} : q_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence cnt_query_other;
        cmd_valid && cmd.op == CEM_OP_COUNT_QUERY && cmd.source != sel_src;
    endsequence

    sequence limit_write_then_query;
        lim_wr ##1 (cmd_valid && cmd.op == CEM_OP_LIMIT_QUERY
            && cmd.source == $past(cmd.source));
    endsequence

    sequence volt_event_read;
        cmd_valid && cmd.op == CEM_OP_EVENT_QUERY && cmd.attr == CEM_ATTR_VOLT;
    endsequence

    count_ceiling_a: assert property (count <= CNT_SAT)
        else $error("count passed its ceiling");

    count_step_a: assert property (ev_hit && !cnt_clr && !cnt_full
        |=> count == $past(count) + 9'h001)
        else $error("event did not add one to the count");

    sat_hold_a: assert property (cnt_full && !cnt_clr |=> cnt_full)
        else $error("saturated count left its ceiling without a clear");

    zero_other_a: assert property (cmd_valid && cmd.op == CEM_OP_COUNT_ZERO
        && cmd.source != sel_src && !ev_hit |=> $stable(count))
        else $error("clear of an unwatched source changed the count");

    select_follow_a: assert property (lim_wr |=> sel_src == $past(cmd.source)
        && (monitor_on == ($past(cmd.data[7:0]) != 8'h00)))
        else $error("limit write did not select its source");

    limit_off_a: assert property (!monitor_on && !cnt_clr |=> $stable(count))
        else $error("count moved while monitoring was off");

    one_source_a: assert property ($onehot0({cond[CEM_ATTR_BUS][9:3],
        cond[CEM_ATTR_BUS][0]}))
        else $error("more than one source flagged over limit");

    range_guard_a: assert property (cmd_valid && cmd.op == CEM_OP_LIMIT_SET
        && cmd.data[15:8] != 8'h00 |=> $stable(active_limit) ##1 rsp_error)
        else $error("out-of-range limit was taken");

    count_other_a: assert property (cnt_query_other |-> ##2 rsp_valid
        && rsp_data == 16'h0000)
        else $error("unwatched source returned a nonzero count");

    limit_back_a: assert property (limit_write_then_query |-> ##2 rsp_valid
        && rsp_data == {8'h00, $past(cmd.data[7:0], 3)})
        else $error("limit query did not return the stored limit");

    volt_cond_a: assert property (##1 cond[CEM_ATTR_VOLT] == {9'h000, $past(faults.volt)})
        else $error("voltage condition does not follow live faults");

    event_rise_a: assert property (((cond[CEM_ATTR_VOLT] & ~$past(cond[CEM_ATTR_VOLT]))
        & ~ev[CEM_ATTR_VOLT]) == 16'h0000)
        else $error("voltage rise not latched in its event register");

    event_clear_a: assert property (volt_event_read |=> ev[CEM_ATTR_VOLT]
        == (cond[CEM_ATTR_VOLT] & ~$past(cond[CEM_ATTR_VOLT])))
        else $error("voltage event register not cleared by its read");

    bus_over_a: assert property (over_limit && sel_src == SRC_BUS_FAULT
        |=> cond[CEM_ATTR_BUS][BUS_FAULT_BIT])
        else $error("fault count over limit not shown in bus condition");

    summary_tie_a: assert property (|(ev[CEM_ATTR_VOLT] & en[CEM_ATTR_VOLT])
        |=> summary[CEM_ATTR_VOLT])
        else $error("enabled voltage event did not raise its summary");

    // Writes and queries alike are answered after exactly two edges
    answer_time_a: assert property (cmd_valid |-> ##2 rsp_valid)
        else $error("command not answered two edges later");

endmodule
`default_nettype wire

// ### bench/cem_backplane_model.sv
// Purpose: Behavioural backplane that raises fault and acknowledge cycles.
// Assumes: Bench clock; one burst of equal events per go pulse.
// Notes: Level lines show the inverted level once a cycle is over.
`timescale 1ns/1ps
`default_nettype none
module cem_backplane_model (
    // Clock
    input wire logic clk,
    // Burst request from the bench
    input wire logic go,
    input wire logic is_ack,
    input wire logic [2:0] level,
    input wire logic [8:0] count,
    output logic busy,
    // Backplane lines, active low except the ack_level code
    output logic bus_error_n,
    output logic ack_strobe_n,
    output logic [2:0] ack_level
);
    ////////////////////////////////////////////////////////////////////////////
    // Idle lines, then bursts: falls eight clocks apart, level settled four clocks before
    initial
    begin
        busy = 1'b0;
        bus_error_n = 1'b1;
        ack_strobe_n = 1'b1;
        ack_level = 3'h0;
        forever
        begin
            @(posedge clk);
            if (go)
            begin
                busy <= 1'b1;
                for (int i = 0; i < int'(count); i++)
                begin
                    if (is_ack)
                        ack_level <= level;
                    repeat (4) @(posedge clk);
                    if (is_ack)
                        ack_strobe_n <= 1'b0;
                    else
                        bus_error_n <= 1'b0;
                    repeat (2) @(posedge clk);
                    ack_strobe_n <= 1'b1;
                    bus_error_n <= 1'b1;
                    @(posedge clk);
                    ack_level <= ~level;  // Stale level must not be trusted
                    @(posedge clk);
                end
                repeat (4) @(posedge clk);
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### bench/cem_monitor_tb.sv
// Purpose: Self-checking bench for the chassis event monitor.
// Assumes: Commands answered within four clocks, one at a time except the back-to-back limit write and query.
// Notes: Inputs change by non-blocking assignment on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module cem_monitor_tb;
    import cem_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Signals
    logic clk;
    logic rst_n;
    logic bus_error_n;
    logic ack_strobe_n;
    logic [2:0] ack_level;
    logic sysfail_n;
    logic acfail_n;
    cem_fault_s faults;
    logic cmd_valid;
    cem_cmd_s cmd;
    logic rsp_valid;
    logic rsp_error;
    logic [15:0] rsp_data;
    logic [5:0] summary;
    logic go;
    logic is_ack;
    logic [2:0] level;
    logic [8:0] count;
    logic busy;
    int fails;
    int checks;
    logic [15:0] cond_exp [5] = '{
        16'h0061,
        16'h0005,
        16'h3001,
        16'h0005,
        16'h0005
    };

    ////////////////////////////////////////////////////////////////////////////
    // Design and backplane
    cem_monitor u_dut (
        .clk(clk), .rst_n(rst_n), .bus_error_n(bus_error_n), .ack_strobe_n(ack_strobe_n),
        .ack_level(ack_level), .sysfail_n(sysfail_n), .acfail_n(acfail_n), .faults(faults),
        .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
        .rsp_data(rsp_data), .summary(summary)
    );
    cem_backplane_model u_bp (
        .clk(clk), .go(go), .is_ack(is_ack), .level(level), .count(count), .busy(busy),
        .bus_error_n(bus_error_n), .ack_strobe_n(ack_strobe_n), .ack_level(ack_level)
    );

    // 50 MHz clock
    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // One command, then its single answer
    task automatic do_cmd(input cem_op_e op, input logic [2:0] src, input logic [2:0] at,
                          input logic [15:0] d, input logic [15:0] exp, input logic err);
        int n;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{op: op, source: src, attr: cem_attr_e'(at), data: d};
        @(posedge clk);
        cmd_valid <= 1'b0;
        while (rsp_valid !== 1'b1 && n < 4)
        begin
            @(negedge clk);
            n++;
        end
        check("rsp_valid", {15'h0, rsp_valid}, 16'h0001);
        check("rsp_error", {15'h0, rsp_error}, {15'h0, err});
        check("rsp_data", rsp_data, exp);
    endtask

    // Burst of backplane events, waited out under a bound
    task automatic events(input logic ack, input logic [2:0] lv, input int n);
        int t;
        t = 0;
        @(posedge clk);
        go <= 1'b1;
        is_ack <= ack;
        level <= lv;
        count <= 9'(n);
        @(posedge clk);
        go <= 1'b0;
        do
        begin
            @(negedge clk);
            t++;
        end
        while (busy === 1'b1 && t < 4000);
        check("busy", {15'h0, busy}, 16'h0000);
    endtask

    task automatic test_done();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        sysfail_n = 1'b1;
        acfail_n = 1'b1;
        faults = '0;
        cmd_valid = 1'b0;
        cmd = '0;
        go = 1'b0;
        is_ack = 1'b0;
        level = 3'h0;
        count = 9'h0;
        fails = 0;
        checks = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // Reset state
        do_cmd(CEM_OP_LIMIT_QUERY, 3'h3, 3'h0, 16'h0, 16'h0, 1'b0);
        do_cmd(CEM_OP_COUNT_QUERY, 3'h0, 3'h0, 16'h0, 16'h0, 1'b0);
        // Level three watched, other sources ignored
        do_cmd(CEM_OP_LIMIT_SET, 3'h3, 3'h0, 16'h0002, 16'h0, 1'b0);
        events(1'b1, 3'h3, 3);
        events(1'b1, 3'h5, 2);
        events(1'b0, 3'h0, 2);
        @(posedge clk);
        sysfail_n <= 1'b0;
        acfail_n <= 1'b0;
        do_cmd(CEM_OP_COUNT_QUERY, 3'h3, 3'h0, 16'h0, 16'h0003, 1'b0);
        do_cmd(CEM_OP_COUNT_QUERY, 3'h5, 3'h0, 16'h0, 16'h0, 1'b0);
        do_cmd(CEM_OP_COUNT_QUERY, 3'h0, 3'h0, 16'h0, 16'h0, 1'b0);
        do_cmd(CEM_OP_LIMIT_QUERY, 3'h3, 3'h0, 16'h0, 16'h0002, 1'b0);
        do_cmd(CEM_OP_COND_QUERY, 3'h0, 3'h5, 16'h0, 16'h0026, 1'b0);
        // Clear acts on the watched source only
        do_cmd(CEM_OP_COUNT_ZERO, 3'h0, 3'h0, 16'h0, 16'h0, 1'b0);
        do_cmd(CEM_OP_COUNT_QUERY, 3'h3, 3'h0, 16'h0, 16'h0003, 1'b0);
        do_cmd(CEM_OP_COUNT_ZERO, 3'h3, 3'h0, 16'h0, 16'h0, 1'b0);
        do_cmd(CEM_OP_COUNT_QUERY, 3'h3, 3'h0, 16'h0, 16'h0, 1'b0);
        // Back-to-back limit rewrite and readback of the same source
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{op: CEM_OP_LIMIT_SET, source: 3'h3, attr: CEM_ATTR_VOLT, data: 16'h0002};
        @(posedge clk);
        cmd <= '{op: CEM_OP_LIMIT_QUERY, source: 3'h3, attr: CEM_ATTR_VOLT, data: 16'h0000};
        @(posedge clk);
        cmd_valid <= 1'b0;
        @(negedge clk);
        check("rsp_valid", {15'h0, rsp_valid}, 16'h0001);
        @(negedge clk);
        check("rsp_data", rsp_data, 16'h0002);
        // Out-of-range limit refused; zero limit stops counting
        do_cmd(CEM_OP_LIMIT_SET, 3'h3, 3'h0, 16'h0100, 16'h0, 1'b1);
        do_cmd(CEM_OP_LIMIT_QUERY, 3'h3, 3'h0, 16'h0, 16'h0002, 1'b0);
        do_cmd(CEM_OP_LIMIT_SET, 3'h3, 3'h0, 16'h0, 16'h0, 1'b0);
        events(1'b1, 3'h3, 2);
        do_cmd(CEM_OP_COUNT_QUERY, 3'h3, 3'h0, 16'h0, 16'h0, 1'b0);
        // Saturation, left by clear and then by reselection
        for (int k = 0; k < 2; k++)
        begin
            do_cmd(CEM_OP_LIMIT_SET, 3'h0, 3'h0, 16'h00ff, 16'h0, 1'b0);
            events(1'b0, 3'h0, 260);
            do_cmd(CEM_OP_COUNT_QUERY, 3'h0, 3'h0, 16'h0, 16'h0100, 1'b0);
            if (k == 0)
                do_cmd(CEM_OP_COUNT_ZERO, 3'h0, 3'h0, 16'h0, 16'h0, 1'b0);
            else
                do_cmd(CEM_OP_LIMIT_SET, 3'h1, 3'h0, 16'h0005, 16'h0, 1'b0);
            do_cmd(CEM_OP_COUNT_QUERY, 3'(k), 3'h0, 16'h0, 16'h0, 1'b0);
        end
        // Condition maps, event latch and clear on read
        @(posedge clk);
        faults <= '{volt: 7'h61, curr: 7'h05, slot: 13'h1001, ambient: 1'b1,
                    fan: 3'h2, elapsed: 3'h5};
        repeat (3) @(negedge clk);
        for (int a = 0; a < 5; a++)
        begin
            do_cmd(CEM_OP_COND_QUERY, 3'h0, 3'(a), 16'h0, cond_exp[a], 1'b0);
            do_cmd(CEM_OP_EVENT_QUERY, 3'h0, 3'(a), 16'h0, cond_exp[a], 1'b0);
            do_cmd(CEM_OP_EVENT_QUERY, 3'h0, 3'(a), 16'h0, 16'h0, 1'b0);
        end
        do_cmd(CEM_OP_COND_QUERY, 3'h0, 3'h6, 16'h0, 16'h0, 1'b1);
        // Enabled event drives the summary bit
        do_cmd(CEM_OP_ENABLE_SET, 3'h0, 3'h0, 16'h0001, 16'h0, 1'b0);
        do_cmd(CEM_OP_ENABLE_QUERY, 3'h0, 3'h0, 16'h0, 16'h0001, 1'b0);
        check("summary", {10'h0, summary}, 16'h0);
        @(posedge clk) faults.volt <= 7'h60;
        repeat (3) @(posedge clk);
        faults.volt <= 7'h61;
        repeat (4) @(negedge clk);
        check("summary", {10'h0, summary}, 16'h0001);
        do_cmd(CEM_OP_EVENT_QUERY, 3'h0, 3'h0, 16'h0, 16'h0001, 1'b0);
        repeat (3) @(negedge clk);
        check("summary", {10'h0, summary}, 16'h0);
        @(posedge clk) faults <= '0;
        repeat (3) @(negedge clk);
        do_cmd(CEM_OP_COND_QUERY, 3'h0, 3'h0, 16'h0, 16'h0, 1'b0);
        test_done();
    end
endmodule
`default_nettype wire
